/* File: rtl/bisum_consts.svh */
`ifndef BISUM_CONSTS_SVH
`define BISUM_CONSTS_SVH

// ----------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------
`define BISUM_IDX_SUMMARY 14'h0B00
`define BISUM_IDX_BLK_EN 14'h0B01
`define BISUM_IDX_LOOP 14'h0B0A
`define BISUM_IDX_DL0 14'h0B06
`define BISUM_IDX_DL1 14'h0B16
`define BISUM_IDX_DL2 14'h0B26
`define BISUM_IDX_DL3 14'h0B10
`define BISUM_IDX_DL4 14'h0B18
`define BISUM_IDX_DL5 14'h0B28
`define BISUM_IDX_SLIP 14'h0B08
`define BISUM_IDX_AL0 14'h0B02
`define BISUM_IDX_AL1 14'h0B0E
`define BISUM_IDX_AL2 14'h0B40
`define BISUM_IDX_FRAMER 14'h0B04
`define BISUM_IDX_CLK_CFG 14'h0100
`define BISUM_IDX_SRC_EN 14'h0BF0

// ----------------------------------------
// summary bit positions and the clock config enable bit
// ----------------------------------------
`define BISUM_BIT_FRAMER 0
`define BISUM_BIT_ALARM 1
`define BISUM_BIT_SLIP 2
`define BISUM_BIT_DLINK 3
`define BISUM_BIT_TICK 4
`define BISUM_BIT_CLKLOST 5
`define BISUM_BIT_LOOP 6
`define BISUM_BIT_CLK_DET_EN 0

// ----------------------------------------
// pending entry positions in the source vector
// ----------------------------------------
`define BISUM_ENT_LOOP 0
`define BISUM_ENT_DL_LO 1
`define BISUM_ENT_DL_HI 6
`define BISUM_ENT_SLIP 7
`define BISUM_ENT_AL_LO 8
`define BISUM_ENT_AL_HI 10
`define BISUM_ENT_FRAMER 11

// ----------------------------------------
// reset values
// ----------------------------------------
`define BISUM_RST_WORD 32'h0000_0000
`define BISUM_RST_BITS7 7'h00

`endif

/* File: rtl/bisum_pkg.sv */
// ----------------------------------------
// shared types of the interrupt summary block
// ----------------------------------------
package bisum_pkg;
    typedef logic [6:0] bisum_bits_t;
    typedef enum logic [1:0]
    {
        BISUM_TR_IDLE = 2'b00,
        BISUM_TR_BUSY = 2'b01,
        BISUM_TR_NONSEQ = 2'b10,
        BISUM_TR_SEQ = 2'b11
    } bisum_htrans_t;
endpackage

/* File: rtl/bisum_pend.sv */
`timescale 1ns/1ps
`include "bisum_consts.svh"

// ----------------------------------------
// sticky pending flags, one per source status register
// ----------------------------------------
module bisum_pend
#(
    parameter int N = 12
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // per-entry set and read-clear pulses
    input wire logic [N-1:0] set_evt,
    input wire logic [N-1:0] rd_clr,
    // flags
    output logic [N-1:0] pend
);
    import bisum_pkg::*;

    // a request that lands in the clearing cycle survives the read
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ent
            logic ent_q;

            // each entry owns its flop, so no two processes write one variable
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    ent_q <= 1'b0;
                else if (set_evt[g])
                    ent_q <= 1'b1;
                else if (rd_clr[g])
                    ent_q <= 1'b0;
            end

            assign pend[g] = ent_q;

            pend_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
                rd_clr[g] && !set_evt[g] |=> !pend[g])
                else $error("pending flag not cleared by its read");
            pend_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
                pend[g] && !rd_clr[g] |=> pend[g])
                else $error("pending flag dropped without a read");
        end
    endgenerate

endmodule // bisum_pend

/* File: rtl/bisum_top.sv */
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "bisum_consts.svh"

// Notes on behaviour
// - bit6 set while loop code request pending
// - bit6 clears on loop code status read
// - bit5 follows current recovered clock loss
// - bit5 active only with loss detection enabled
// - bit4 follows current one second tick
// - bit3 set while any data link pending
// - bit3 clears on reading raising link register
// - bit2 set while slip request pending
// - bit2 clears on slip status read
// - bit1 set while alarm request pending
// - bit1 clears on reading raising alarm register
// - bit0 framer pending, clears on framer read
// - irq needs block and source enable
module bisum_top
#(
    parameter int NSRC = 12
)
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire bisum_pkg::bisum_htrans_t htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // request pulses from the source blocks, one per status register
    input wire logic [NSRC-1:0] src_event,
    // level indications from the receive framer
    input wire logic recovered_clock_lost,
    input wire logic second_tick_pending,
    // interrupt to the host
    output logic irq
);
    import bisum_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------

    logic [13:0] a_idx;
    logic a_inrange;
    logic a_take;
    logic rd_take;
    logic wr_take;
    logic [NSRC-1:0] a_hit;
    logic [NSRC-1:0] rd_clr;

    // only the low sixteen address bits carry registers; the rest must be zero
    assign a_idx = haddr[15:2];
    assign a_inrange = (haddr[31:16] == 16'h0000) && (haddr[1:0] == 2'b00);
    assign a_take = hsel && hready && (htrans == BISUM_TR_NONSEQ || htrans == BISUM_TR_SEQ);
    assign rd_take = a_take && !hwrite;
    assign wr_take = a_take && hwrite;

    // which source status register an index names
    function automatic logic [NSRC-1:0] hit_of(input logic [13:0] idx);
        logic [NSRC-1:0] h;
        h = '0;
        unique case (idx)
            `BISUM_IDX_LOOP: h[`BISUM_ENT_LOOP] = 1'b1;
            `BISUM_IDX_DL0: h[`BISUM_ENT_DL_LO] = 1'b1;
            `BISUM_IDX_DL1: h[`BISUM_ENT_DL_LO + 1] = 1'b1;
            `BISUM_IDX_DL2: h[`BISUM_ENT_DL_LO + 2] = 1'b1;
            `BISUM_IDX_DL3: h[`BISUM_ENT_DL_LO + 3] = 1'b1;
            `BISUM_IDX_DL4: h[`BISUM_ENT_DL_LO + 4] = 1'b1;
            `BISUM_IDX_DL5: h[`BISUM_ENT_DL_HI] = 1'b1;
            `BISUM_IDX_SLIP: h[`BISUM_ENT_SLIP] = 1'b1;
            `BISUM_IDX_AL0: h[`BISUM_ENT_AL_LO] = 1'b1;
            `BISUM_IDX_AL1: h[`BISUM_ENT_AL_LO + 1] = 1'b1;
            `BISUM_IDX_AL2: h[`BISUM_ENT_AL_HI] = 1'b1;
            `BISUM_IDX_FRAMER: h[`BISUM_ENT_FRAMER] = 1'b1;
            default: h = '0;
        endcase
        return h;
    endfunction

    assign a_hit = a_inrange ? hit_of(a_idx) : '0;
    // a read of a source status register retires its request
    assign rd_clr = rd_take ? a_hit : '0;

    // ----------------------------------------
    // pending request flags
    // ----------------------------------------

    logic [NSRC-1:0] pend;

    bisum_pend #(
        .N(NSRC)
    ) u_pend (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_evt(src_event),
        .rd_clr(rd_clr),
        .pend(pend)
    );

    // ----------------------------------------
    // framer level indications
    // ----------------------------------------

    logic lost_q;
    logic tick_q;

    // registered so the summary only shows what the framer declared last cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lost_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            lost_q <= recovered_clock_lost;
            tick_q <= second_tick_pending;
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------

    logic wr_q;
    logic [13:0] wr_idx_q;
    logic wr_ok_q;
    bisum_bits_t blk_en_q;
    bisum_bits_t src_en_q;
    logic clk_det_en_q;

    // write address phase is held for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            wr_idx_q <= 14'h0000;
            wr_ok_q <= 1'b0;
        end
        else
        begin
            wr_q <= wr_take;
            wr_idx_q <= a_idx;
            wr_ok_q <= a_inrange;
        end
    end

    // data phase writes; the summary index has no case here, so writes to it vanish
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            blk_en_q <= `BISUM_RST_BITS7;
            src_en_q <= `BISUM_RST_BITS7;
            clk_det_en_q <= 1'b0;
        end
        else if (wr_q && wr_ok_q)
        begin
            if (wr_idx_q == `BISUM_IDX_BLK_EN)
                blk_en_q <= hwdata[6:0];
            if (wr_idx_q == `BISUM_IDX_SRC_EN)
                src_en_q <= hwdata[6:0];
            if (wr_idx_q == `BISUM_IDX_CLK_CFG)
                clk_det_en_q <= hwdata[`BISUM_BIT_CLK_DET_EN];
        end
    end

    // ----------------------------------------
    // summary word
    // ----------------------------------------

    bisum_bits_t sum_w;

    // a combinational view of the flags; reading it disturbs nothing
    always_comb
    begin
        sum_w = `BISUM_RST_BITS7;
        sum_w[`BISUM_BIT_LOOP] = pend[`BISUM_ENT_LOOP];
        sum_w[`BISUM_BIT_CLKLOST] = lost_q && clk_det_en_q;
        sum_w[`BISUM_BIT_TICK] = tick_q;
        sum_w[`BISUM_BIT_DLINK] = |pend[`BISUM_ENT_DL_HI:`BISUM_ENT_DL_LO];
        sum_w[`BISUM_BIT_SLIP] = pend[`BISUM_ENT_SLIP];
        sum_w[`BISUM_BIT_ALARM] = |pend[`BISUM_ENT_AL_HI:`BISUM_ENT_AL_LO];
        sum_w[`BISUM_BIT_FRAMER] = pend[`BISUM_ENT_FRAMER];
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------

    logic [31:0] rd_d;
    logic [31:0] hrdata_q;

    // picked at the address phase so the data phase needs no wait state
    always_comb
    begin
        rd_d = `BISUM_RST_WORD;
        if (a_inrange)
        begin
            if (a_idx == `BISUM_IDX_SUMMARY)
                rd_d = {25'h000_0000, sum_w};
            else if (a_idx == `BISUM_IDX_BLK_EN)
                rd_d = {25'h000_0000, blk_en_q};
            else if (a_idx == `BISUM_IDX_SRC_EN)
                rd_d = {25'h000_0000, src_en_q};
            else if (a_idx == `BISUM_IDX_CLK_CFG)
                rd_d = {31'h0000_0000, clk_det_en_q};
            else if (|a_hit)
                rd_d = {31'h0000_0000, |(a_hit & pend)};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= `BISUM_RST_WORD;
        else if (rd_take)
            hrdata_q <= rd_d;
    end

    assign hrdata = hrdata_q;
    // every transfer completes at once with an okay response
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ----------------------------------------
    // interrupt output
    // ----------------------------------------

    logic irq_q;

    // block and source enables must both be set; a pending bit alone stays quiet
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(sum_w & blk_en_q & src_en_q);
    end

    assign irq = irq_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------

    // every check below runs on the bus clock; all but the two reset checks sleep through reset
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic sum_rd;
    assign sum_rd = rd_take && a_inrange && (a_idx == `BISUM_IDX_SUMMARY);

    // sticky sources show one cycle after their pulse
    loop_set_a: assert property (src_event[`BISUM_ENT_LOOP] |=> sum_w[`BISUM_BIT_LOOP])
        else $error("loop code request not shown");
    loop_clear_a: assert property (rd_take && a_inrange && a_idx == `BISUM_IDX_LOOP
        && !src_event[`BISUM_ENT_LOOP] |=> !sum_w[`BISUM_BIT_LOOP])
        else $error("loop code bit not cleared by read");
    // level bits follow the framer through one register; a landing enable write is excluded
    clk_lost_a: assert property (recovered_clock_lost && clk_det_en_q
        && !(wr_q && wr_idx_q == `BISUM_IDX_CLK_CFG) |=> sum_w[`BISUM_BIT_CLKLOST])
        else $error("clock loss not shown");
    clk_quiet_a: assert property (!clk_det_en_q || !lost_q |-> !sum_w[`BISUM_BIT_CLKLOST])
        else $error("clock loss shown while disabled or absent");
    tick_follow_a: assert property (##1 sum_w[`BISUM_BIT_TICK] == $past(second_tick_pending))
        else $error("tick bit does not follow framer");
    dlink_set_a: assert property (|src_event[`BISUM_ENT_DL_HI:`BISUM_ENT_DL_LO]
        |=> sum_w[`BISUM_BIT_DLINK])
        else $error("data link request not shown");
    dlink_clear_a: assert property (sum_w[`BISUM_BIT_DLINK] && !(|src_event)
        && $countones(pend[`BISUM_ENT_DL_HI:`BISUM_ENT_DL_LO]) == 1
        && (|(rd_clr[`BISUM_ENT_DL_HI:`BISUM_ENT_DL_LO] & pend[`BISUM_ENT_DL_HI:`BISUM_ENT_DL_LO]))
        |=> !sum_w[`BISUM_BIT_DLINK])
        else $error("data link bit not cleared by read");
    slip_set_a: assert property (src_event[`BISUM_ENT_SLIP] |=> sum_w[`BISUM_BIT_SLIP]
        ##1 (sum_w[`BISUM_BIT_SLIP] || $past(rd_clr[`BISUM_ENT_SLIP])))
        else $error("slip request lost");
    alarm_set_a: assert property (|src_event[`BISUM_ENT_AL_HI:`BISUM_ENT_AL_LO]
        |=> sum_w[`BISUM_BIT_ALARM])
        else $error("alarm request not shown");
    frame_clear_a: assert property (rd_clr[`BISUM_ENT_FRAMER] && !src_event[`BISUM_ENT_FRAMER]
        |=> !sum_w[`BISUM_BIT_FRAMER])
        else $error("framer bit not cleared by read");
    // the interrupt is a registered copy of the gated summary
    irq_gate_a: assert property (##1 irq == $past(|(sum_w & blk_en_q & src_en_q)))
        else $error("interrupt not gated by both enables");
    sum_read_a: assert property (sum_rd && !(|src_event) && $stable(lost_q)
        |=> $stable(pend) && hrdata[31:7] == 25'h000_0000)
        else $error("summary read disturbed state or bit7 set");
    sum_reset_a: assert property (@(posedge hclk) disable iff (1'b0)
        $rose(hresetn) |-> sum_w == `BISUM_RST_BITS7)
        else $error("summary not zero after reset");
    // a read of the only pending alarm flag that meets no new request must retire the alarm summary
    alarm_clear_a: assert property (sum_w[`BISUM_BIT_ALARM] && !(|src_event)
        && $countones(pend[`BISUM_ENT_AL_HI:`BISUM_ENT_AL_LO]) == 1
        && (|(rd_clr[`BISUM_ENT_AL_HI:`BISUM_ENT_AL_LO] & pend[`BISUM_ENT_AL_HI:`BISUM_ENT_AL_LO]))
        |=> !sum_w[`BISUM_BIT_ALARM])
        else $error("alarm bit not cleared by read");
    slip_clear_a: assert property (rd_clr[`BISUM_ENT_SLIP] && !src_event[`BISUM_ENT_SLIP]
        |=> !sum_w[`BISUM_BIT_SLIP])
        else $error("slip bit not cleared by read");
    // sticky bits only leave through their own status read
    loop_hold_a: assert property (sum_w[`BISUM_BIT_LOOP] && !rd_clr[`BISUM_ENT_LOOP]
        |=> sum_w[`BISUM_BIT_LOOP])
        else $error("loop code bit dropped without a read");
    // a status read hands back the flag as it stood before the clear
    src_ack_a: assert property (rd_take && (|rd_clr)
        |=> hrdata[0] == $past(|(rd_clr & pend)))
        else $error("status read returned the wrong flag");
    // writes aimed at the summary must not leak into the enables
    sum_write_a: assert property (wr_q && wr_idx_q == `BISUM_IDX_SUMMARY
        |=> $stable(blk_en_q) && $stable(src_en_q) && $stable(clk_det_en_q))
        else $error("summary write changed a register");
    // the interrupt must be quiet as reset lets go
    irq_reset_a: assert property (@(posedge hclk) disable iff (1'b0)
        $rose(hresetn) |-> !irq)
        else $error("interrupt high after reset");

    // ----------------------------------------
    // cover points
    // ----------------------------------------

    irq_seen_c: cover property (src_event[`BISUM_ENT_LOOP] ##[1:4] irq);
    dl_service_c: cover property (sum_w[`BISUM_BIT_DLINK] ##[1:20] !sum_w[`BISUM_BIT_DLINK]);
    set_on_clear_c: cover property (|(src_event & rd_clr));
    sum_read_c: cover property (sum_rd ##1 hrdata[`BISUM_BIT_ALARM]);
    clk_lost_c: cover property (sum_w[`BISUM_BIT_CLKLOST] ##1 !sum_w[`BISUM_BIT_CLKLOST]);

endmodule // bisum_top

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
`include "bisum_consts.svh"

module tb_top;
    import bisum_pkg::*;

    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    bisum_htrans_t htrans = BISUM_TR_IDLE;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [11:0] src_event = 12'h000;
    logic recovered_clock_lost = 1'b0;
    logic second_tick_pending = 1'b0;
    logic irq;
    int fails = 0;
    int num_checks = 0;

    // one slave only, so its ready is the bus ready
    assign hready = hreadyout;

    // 25 MHz clock
    always #20 hclk = ~hclk;

    bisum_top uut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_event(src_event),
        .recovered_clock_lost(recovered_clock_lost), .second_tick_pending(second_tick_pending),
        .irq(irq)
    );

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] a4(input logic [13:0] idx);
        return {16'h0000, idx, 2'b00};
    endfunction

    // called right after a rising edge; returns right after the data phase edge
    task automatic xfer(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                        output logic [31:0] data);
        hsel <= 1'b1;
        haddr <= a4(idx);
        hwrite <= wr;
        htrans <= BISUM_TR_NONSEQ;
        // no local limit: only the watchdog ends a wait
        do begin @(posedge hclk); end while (hready !== 1'b1);
        htrans <= BISUM_TR_IDLE;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); end while (hready !== 1'b1);
        data = hrdata;
    endtask

    task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, idx, 32'h0000_0000, d);
        check_word(d, exp);
        check_bit(hresp, 1'b0);
        check_bit(hreadyout, 1'b1);
    endtask

    task automatic wr(input logic [13:0] idx, input logic [31:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, v, d);
    endtask

    // one quiet edge after the pulse, so two calls never drive src_event in one step
    task automatic pulse(input int e);
        src_event[e] <= 1'b1;
        @(posedge hclk);
        src_event <= 12'h000;
        @(posedge hclk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // table of sticky sources: status register index and summary bit
    // ----------------------------------------
    logic [13:0] src_reg [12] = '{`BISUM_IDX_LOOP, `BISUM_IDX_DL0, `BISUM_IDX_DL1, `BISUM_IDX_DL2,
        `BISUM_IDX_DL3, `BISUM_IDX_DL4, `BISUM_IDX_DL5, `BISUM_IDX_SLIP, `BISUM_IDX_AL0,
        `BISUM_IDX_AL1, `BISUM_IDX_AL2, `BISUM_IDX_FRAMER};
    logic [31:0] src_bit [12] = '{32'h0000_0040, 32'h0000_0008, 32'h0000_0008, 32'h0000_0008,
        32'h0000_0008, 32'h0000_0008, 32'h0000_0008, 32'h0000_0004, 32'h0000_0002,
        32'h0000_0002, 32'h0000_0002, 32'h0000_0001};

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge hclk);
        check_bit(irq, 1'b0);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
        rd_chk(`BISUM_IDX_BLK_EN, 32'h0000_0000);
        rd_chk(`BISUM_IDX_SRC_EN, 32'h0000_0000);
        rd_chk(`BISUM_IDX_CLK_CFG, 32'h0000_0000);
        // each sticky source sets its bit, and reading its status register clears it
        for (int i = 0; i < 12; i++)
        begin
            pulse(i);
            rd_chk(`BISUM_IDX_SUMMARY, src_bit[i]);
            rd_chk(`BISUM_IDX_SUMMARY, src_bit[i]);
            rd_chk(src_reg[i], 32'h0000_0001);
            rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
            rd_chk(src_reg[i], 32'h0000_0000);
        end
        // two link controllers pending: the bit stays until both are read
        pulse(1);
        pulse(4);
        rd_chk(`BISUM_IDX_DL0, 32'h0000_0001);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0008);
        rd_chk(`BISUM_IDX_DL3, 32'h0000_0001);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
        // a slip request on the very edge of its status read survives the read
        fork
            pulse(7);
            rd_chk(`BISUM_IDX_SLIP, 32'h0000_0000);
        join
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0004);
        rd_chk(`BISUM_IDX_SLIP, 32'h0000_0001);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
        // level indications, clock loss gated by its detection enable
        second_tick_pending <= 1'b1;
        recovered_clock_lost <= 1'b1;
        repeat (2) @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0010);
        wr(`BISUM_IDX_CLK_CFG, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0030);
        wr(`BISUM_IDX_SUMMARY, 32'hFFFF_FFFF);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0030);
        recovered_clock_lost <= 1'b0;
        repeat (2) @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0010);
        second_tick_pending <= 1'b0;
        repeat (2) @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
        // unmapped place reads zero and drops writes
        wr(14'h3000, 32'h1234_5678);
        rd_chk(14'h3000, 32'h0000_0000);
        // interrupt needs block and source enables together
        pulse(11);
        wr(`BISUM_IDX_BLK_EN, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check_bit(irq, 1'b0);
        wr(`BISUM_IDX_SRC_EN, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check_bit(irq, 1'b1);
        wr(`BISUM_IDX_BLK_EN, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        check_bit(irq, 1'b0);
        wr(`BISUM_IDX_BLK_EN, 32'h0000_0001);
        rd_chk(`BISUM_IDX_BLK_EN, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check_bit(irq, 1'b1);
        rd_chk(`BISUM_IDX_FRAMER, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check_bit(irq, 1'b0);
        // reset in mid-run drops a pending flag
        pulse(7);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`BISUM_IDX_SUMMARY, 32'h0000_0000);
        tally_and_finish();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge hclk);
        fails++;
        tally_and_finish();
    end
endmodule // tb_top
